// file: sim/flash_margin_verify_cmd_irq_tb.sv
// Testbench: register port, blank-check data and fault pulses
// Assumes one clock at 50 MHz and a synchronous reset
`timescale 1ns/10ps
`default_nettype none
module flash_margin_verify_cmd_irq_tb;
  logic clk = 0, rst = 1, wt = 0, df = 0, sf = 0, ee_rd, cirq, eirq;
  flash_seq_pkg::reg_req_s req = '0;
  logic [15:0] rdata, ee_a, ee_d = 16'h0000, bad = 16'hFFFF;
  logic [1:0] um, fm;
  int n_errors = 0, num_checks = 0, n_rd = 0;
  flash_margin_verify_cmd_irq dut (.i_clock(clk), .i_sys_rst(rst), .i_clk_en(1'b1), .i_reg(req), .o_rdata(rdata),
    .i_double_fault(df), .i_single_fault(sf), .i_wait_mode(wt), .o_ee_addr(ee_a), .o_ee_rd(ee_rd),
    .i_ee_rdata(ee_d), .o_user_margin(um), .o_field_margin(fm), .o_cmd_irq(cirq), .o_err_irq(eirq));
  initial forever #10 clk = ~clk;
  // Idle data toggles so a stale word never passes for a fresh one
  always @(posedge clk) begin
    ee_d <= ee_rd ? (ee_a == bad ? 16'h1234 : 16'hFFFF) : ~ee_d;
    if (ee_rd) n_rd <= n_rd + 1;
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] m, exp);
    @(posedge clk) req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk) req.rd <= 1'b0;
    #1 check(rdata & m, exp);
  endtask : rd
  // Loads three words, sets the final index, launches, reads status
  task automatic run(input logic [7:0] c, input logic [1:0] b, input logic [15:0] w1, w2,
                     input logic [2:0] ix, input int n, input logic [15:0] m, exp);
    wr(4'h4, 16'h0000);
    wr(4'h5, {c, 6'h00, b});
    wr(4'h4, 16'h0001);
    wr(4'h5, w1);
    wr(4'h4, 16'h0002);
    wr(4'h5, w2);
    wr(4'h4, {13'h0000, ix});
    wr(4'h0, 16'h0080);
    repeat (n) @(posedge clk);
    rd(4'h0, m, exp);
    if (exp[5]) wr(4'h0, 16'h0020);
  endtask : run
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(4'h0, 16'hFFFF, 16'h0080);
    rd(4'h6, 16'h0003, 16'h0003);
    rd(4'hF, 16'hFFFF, 16'h0000);
    check({cirq, eirq}, 16'h0000);
  endtask : t_reset
  task automatic t_margin;
    for (int k = 0; k < 8; k++) begin
      logic [7:0] c;
      logic [15:0] e;
      c = k[2] ? flash_seq_pkg::CMD_FIELD_MARGIN : flash_seq_pkg::CMD_USER_MARGIN;
      e = k[1:0] == 2'h3 ? 16'h00A0 : 16'h0080;
      run(c, 2'h1, {14'h0000, k[1:0]}, 16'h0000, 3'h1, 0, 16'h00B0, e);
      if (e == 16'h0080) check({14'h0000, k[2] ? fm : um}, {14'h0000, k[1:0]});
    end
    // Field levels serve only the factory check: normal reads come back before anything else
    run(flash_seq_pkg::CMD_FIELD_MARGIN, 2'h1, 16'h0000, 16'h0000, 3'h1, 0, 16'h00B0, 16'h0080);
    check({14'h0000, fm}, 16'h0000);
    run(flash_seq_pkg::CMD_USER_MARGIN, 2'h1, 16'h0001, 16'h0000, 3'h2, 0, 16'h00B0, 16'h00A0);
    run(flash_seq_pkg::CMD_FIELD_MARGIN, 2'h2, 16'h0001, 16'h0000, 3'h1, 0, 16'h00B0, 16'h00A0);
    wr(4'h6, 16'h0002);
    run(flash_seq_pkg::CMD_USER_MARGIN, 2'h0, 16'h0001, 16'h0000, 3'h1, 0, 16'h00B0, 16'h00A0);
    wr(4'h6, 16'h0003);
  endtask : t_margin
  task automatic t_verify(input int n, input logic [15:0] w2, m, exp);
    run(flash_seq_pkg::CMD_ERASE_VERIFY_EE, 2'h0, 16'h0040, w2, 3'h2, n, m, exp);
  endtask : t_verify
  task automatic t_irq;
    @(posedge clk) wt <= 1'b1;
    wr(4'h1, 16'h0080);
    #1 check(16'(cirq), 16'h0001);
    t_verify(0, 16'h0004, 16'h0080, 16'h0000);
    check(16'(cirq), 16'h0000);
    repeat (12) @(posedge clk);
    #1 check(16'(cirq), 16'h0001);
    wr(4'h1, 16'h0000);
    #1 check(16'(cirq), 16'h0000);
    wr(4'h3, 16'h0003);
    df <= 1'b1;
    @(posedge clk) df <= 1'b0;
    #1 check(16'(eirq), 16'h0001);
    rd(4'h2, 16'h0003, 16'h0002);
    wr(4'h3, 16'h0000);
    #1 check(16'(eirq), 16'h0000);
    wr(4'h3, 16'h0001);
    sf <= 1'b1;
    @(posedge clk) sf <= 1'b0;
    #1 check(16'(eirq), 16'h0001);
    wr(4'h2, 16'h0003);
    #1 check(16'(eirq), 16'h0000);
    wt <= 1'b0;
  endtask : t_irq
  task automatic stop_test;
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_margin;
    t_verify(12, 16'h0004, 16'h00B3, 16'h0080);
    check(16'(n_rd), 16'h0004);
    bad <= 16'h0043;
    t_verify(12, 16'h0004, 16'h00B3, 16'h0083);
    bad <= 16'hFFFF;
    t_verify(0, 16'h0000, 16'h00B0, 16'h00A0);
    t_irq;
    stop_test;
  end
  // Generous bound: the whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    n_errors++;
    stop_test;
  end
endmodule : flash_margin_verify_cmd_irq_tb
`default_nettype wire

// file: sim/flash_seq_assertions.sv
// Checker: port-level assertions for the command sequencer
// Assumes the bench keeps the clock enable high
`timescale 1ns/10ps
`default_nettype none
module flash_seq_assertions #(
  parameter int ADDR_W = 16
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire flash_seq_pkg::reg_req_s i_reg,
  input wire logic [15:0] o_rdata,
  input wire logic i_double_fault,
  input wire logic i_single_fault,
  input wire logic [ADDR_W-1:0] o_ee_addr,
  input wire logic o_ee_rd,
  input wire logic [1:0] o_user_margin,
  input wire logic [1:0] o_field_margin,
  input wire logic o_cmd_irq,
  input wire logic o_err_irq
);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire logic st_wr = i_reg.wr && i_reg.addr == flash_seq_pkg::OFS_STATUS;
  wire logic cf_wr = i_reg.wr && i_reg.addr == flash_seq_pkg::OFS_CONFIG;
  wire logic ef_wr = i_reg.wr && i_reg.addr == flash_seq_pkg::OFS_ERR_CONFIG;
  sequence s_word_step;
    o_ee_rd && i_clk_en ##1 i_clk_en ##1 o_ee_rd && i_clk_en;
  endsequence
  sequence s_fault_armed;
    ef_wr && i_reg.wdata[1:0] == 2'h3 ##1 (i_double_fault || i_single_fault) && !i_reg.wr;
  endsequence
  a_rdata_idle: assert property (!$past(i_reg.rd) |-> o_rdata == 16'h0000)
    else $error("read data not idle");
  a_ee_pulse: assert property (o_ee_rd && i_clk_en |=> !o_ee_rd)
    else $error("word read pulse too long");
  a_ee_step: assert property (s_word_step |-> o_ee_addr == $past(o_ee_addr, 2) + ADDR_W'(1))
    else $error("word address did not step by one");
  a_ee_start: assert property ($rose(o_ee_rd) |-> $past(st_wr) || $past(o_ee_rd, 2))
    else $error("word read without launch");
  a_cmd_irq_off: assert property (cf_wr && !i_reg.wdata[7] |=> !o_cmd_irq)
    else $error("command interrupt while disabled");
  a_err_irq_off: assert property (ef_wr && i_reg.wdata[1:0] == 2'h0 |=> !o_err_irq)
    else $error("error interrupt while disabled");
  a_err_irq_on: assert property (s_fault_armed |=> o_err_irq)
    else $error("error interrupt missing after fault");
  a_margin_hold: assert property (!st_wr |=> $stable(o_user_margin) && $stable(o_field_margin))
    else $error("margin changed without launch");
endmodule : flash_seq_assertions
bind flash_margin_verify_cmd_irq flash_seq_assertions #(.ADDR_W(ADDR_W)) u_chk (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_reg(i_reg), .o_rdata(o_rdata), .i_double_fault(i_double_fault),
  .i_single_fault(i_single_fault), .o_ee_addr(o_ee_addr), .o_ee_rd(o_ee_rd), .o_user_margin(o_user_margin),
  .o_field_margin(o_field_margin), .o_cmd_irq(o_cmd_irq), .o_err_irq(o_err_irq));
`default_nettype wire

// file: src/flash_margin_verify_cmd_irq.sv
// Command sequencer: margin-level commands, EEPROM erase-verify, interrupts
// Assumes synchronous inputs, EEPROM read data one cycle after its address
// Functional notes
// - Margin command errors unless word index one
// - Margin command errors when mode forbids it
// - Margin command errors on invalid block select
// - Margin command errors on undefined margin value
// - Erase-verify checks section, then sets complete
// - Any non-erased word sets both verify bits
// - Three sources: complete, double and single fault
// - Command interrupt needs complete flag and enable
// - Error interrupt ORs both gated fault flags
// - Wait mode changes nothing; complete wakes processor
// - Margin values zero, one, two accepted
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module flash_margin_verify_cmd_irq #(
  parameter int ADDR_W = 16
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire flash_seq_pkg::reg_req_s i_reg,
  output logic [15:0] o_rdata,
  input wire logic i_double_fault,
  input wire logic i_single_fault,
  input wire logic i_wait_mode,
  output logic [ADDR_W-1:0] o_ee_addr,
  output logic o_ee_rd,
  input wire logic [15:0] i_ee_rdata,
  output logic [1:0] o_user_margin,
  output logic [1:0] o_field_margin,
  output logic o_cmd_irq,
  output logic o_err_irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_CHECK = 3'b100
  } seq_state_e;

  seq_state_e state_ff;
  logic ccf_ff;
  logic acc_ff;
  logic prot_ff;
  logic vhi_ff;
  logic vlo_ff;
  logic [7:0] status_word;
  logic [7:0] config_ff;
  logic [1:0] err_stat_ff;
  logic [1:0] err_cfg_ff;
  logic [2:0] word_index_ff;
  logic [15:0] param_ff [0:7];
  logic [1:0] mode_allow_ff;
  logic [1:0] user_margin_ff;
  logic [1:0] field_margin_ff;
  logic [ADDR_W-1:0] ee_addr_ff;
  logic [15:0] remain_ff;
  logic fail_ff;
  logic ee_rd_ff;
  logic [15:0] rdata_ff;

  logic wr_stat;
  logic launch;
  logic [7:0] code;
  logic [1:0] blk;
  logic [15:0] level;
  logic is_user;
  logic is_field;
  logic is_margin;
  logic is_ev;
  logic margin_err;
  logic ev_err;
  logic level_ok;
  logic start_ok;
  logic start_ev;
  logic flag_err;
  logic clr_stat;
  logic word_bad;
  logic last_word;
  logic next_word;

  assign wr_stat = i_clk_en && i_reg.wr && (i_reg.addr == flash_seq_pkg::OFS_STATUS);
  // Launch only when idle with complete flag set, by writing one to it; only erase-verify then clears the flag
  assign launch = wr_stat && i_reg.wdata[flash_seq_pkg::STAT_CCF] && (state_ff == ST_IDLE)
                  && ccf_ff;
  assign code = param_ff[0][15:8];
  assign blk = param_ff[0][1:0];
  assign level = param_ff[1];
  assign is_user = (code == flash_seq_pkg::CMD_USER_MARGIN);
  assign is_field = (code == flash_seq_pkg::CMD_FIELD_MARGIN);
  assign is_margin = is_user || is_field;
  assign is_ev = (code == flash_seq_pkg::CMD_ERASE_VERIFY_EE);
  assign level_ok = (level == flash_seq_pkg::MARGIN_NORMAL) || (level == flash_seq_pkg::MARGIN_ERASED)
                    || (level == flash_seq_pkg::MARGIN_PROGRAMMED);
  assign margin_err = (word_index_ff != flash_seq_pkg::IDX_ONE)
                      || (is_user && !mode_allow_ff[0]) || (is_field && !mode_allow_ff[1])
                      || ((blk != flash_seq_pkg::EE_BLOCK) && (blk != flash_seq_pkg::PF_BLOCK))
                      || !level_ok;
  assign ev_err = (word_index_ff != flash_seq_pkg::IDX_TWO) || (blk != flash_seq_pkg::EE_BLOCK)
                  || (param_ff[2] == 16'h0000);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      config_ff <= 8'h00;
      err_cfg_ff <= 2'h0;
      word_index_ff <= 3'h0;
      mode_allow_ff <= 2'h3;
    end else if (i_clk_en && i_reg.wr) begin
      unique case (i_reg.addr)
        flash_seq_pkg::OFS_CONFIG: config_ff <= i_reg.wdata[7:0];
        flash_seq_pkg::OFS_ERR_CONFIG: err_cfg_ff <= i_reg.wdata[1:0];
        flash_seq_pkg::OFS_WORD_INDEX: word_index_ff <= i_reg.wdata[2:0];
        flash_seq_pkg::OFS_MODE: mode_allow_ff <= i_reg.wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // Parameter words indexed by the word index, one word per slot
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_param
      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          param_ff[g] <= 16'h0000;
        end else if (i_clk_en && i_reg.wr && (i_reg.addr == flash_seq_pkg::OFS_PARAM)
                     && (word_index_ff == 3'(g)) && (state_ff == ST_IDLE)) begin
          param_ff[g] <= i_reg.wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Keeps running while the processor waits: wait mode is not looked at
  // A launch with pending errors is ignored, as software must clear them first
  assign start_ok = launch && !acc_ff && !prot_ff;
  assign start_ev = start_ok && is_ev && !ev_err;
  assign flag_err = start_ok && (is_margin ? margin_err : (!is_ev || ev_err));
  assign clr_stat = wr_stat && (state_ff == ST_IDLE);
  assign word_bad = (i_ee_rdata != flash_seq_pkg::ERASED_WORD);
  assign last_word = (state_ff == ST_CHECK) && (remain_ff == 16'h0001);
  assign next_word = (state_ff == ST_CHECK) && (remain_ff != 16'h0001);

  // Unused status bits read as zero
  always_comb begin
    status_word = 8'h00;
    status_word[flash_seq_pkg::STAT_CCF] = ccf_ff;
    status_word[flash_seq_pkg::STAT_ACC] = acc_ff;
    status_word[flash_seq_pkg::STAT_PROT] = prot_ff;
    status_word[flash_seq_pkg::STAT_VHI] = vhi_ff;
    status_word[flash_seq_pkg::STAT_VLO] = vlo_ff;
  end

  // Each word takes a read cycle and a check cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_ff <= ST_IDLE;
    end else if (i_clk_en) begin
      unique case (state_ff)
        ST_IDLE: begin
          if (start_ev) begin
            state_ff <= ST_READ;
          end
        end
        ST_READ: begin
          state_ff <= ST_CHECK;
        end
        ST_CHECK: begin
          if (last_word) begin
            state_ff <= ST_IDLE;
          end else begin
            state_ff <= ST_READ;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Complete drops only for the multi-cycle check; margin commands finish at once
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ccf_ff <= flash_seq_pkg::STATUS_RESET[flash_seq_pkg::STAT_CCF];
    end else if (i_clk_en) begin
      if (start_ev) begin
        ccf_ff <= 1'b0;
      end else if (last_word) begin
        ccf_ff <= 1'b1;
      end
    end
  end

  // Error bits clear by writing one while idle; a new error wins
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      acc_ff <= flash_seq_pkg::STATUS_RESET[flash_seq_pkg::STAT_ACC];
      prot_ff <= flash_seq_pkg::STATUS_RESET[flash_seq_pkg::STAT_PROT];
    end else if (i_clk_en) begin
      if (flag_err) begin
        acc_ff <= 1'b1;
      end else if (clr_stat && i_reg.wdata[flash_seq_pkg::STAT_ACC]) begin
        acc_ff <= 1'b0;
      end
      // No protected areas here, so this bit only ever clears
      if (clr_stat && i_reg.wdata[flash_seq_pkg::STAT_PROT]) begin
        prot_ff <= 1'b0;
      end
    end
  end

  // Both verify bits report a failed blank check together
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      vhi_ff <= flash_seq_pkg::STATUS_RESET[flash_seq_pkg::STAT_VHI];
      vlo_ff <= flash_seq_pkg::STATUS_RESET[flash_seq_pkg::STAT_VLO];
    end else if (i_clk_en) begin
      if (start_ok) begin
        vhi_ff <= 1'b0;
        vlo_ff <= 1'b0;
      end else if (last_word && (fail_ff || word_bad)) begin
        vhi_ff <= 1'b1;
        vlo_ff <= 1'b1;
      end
    end
  end

  // Levels change only on an accepted command, so a refused one leaves them as they were
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      user_margin_ff <= 2'h0;
      field_margin_ff <= 2'h0;
    end else if (i_clk_en && start_ok && is_margin && !margin_err) begin
      if (is_user) begin
        user_margin_ff <= level[1:0];
      end else begin
        field_margin_ff <= level[1:0];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ee_addr_ff <= '0;
      remain_ff <= 16'h0000;
    end else if (i_clk_en) begin
      if (start_ev) begin
        ee_addr_ff <= param_ff[1][ADDR_W-1:0];
        remain_ff <= param_ff[2];
      end else if (next_word) begin
        ee_addr_ff <= ee_addr_ff + ADDR_W'(1);
        remain_ff <= remain_ff - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      fail_ff <= 1'b0;
      ee_rd_ff <= 1'b0;
    end else if (i_clk_en) begin
      ee_rd_ff <= start_ev || next_word;
      if (start_ev) begin
        fail_ff <= 1'b0;
      end else if ((state_ff == ST_CHECK) && word_bad) begin
        fail_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // ECC fault flags
  // ----------------------------------------
  // Set wins over a simultaneous write-one clear
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      err_stat_ff <= 2'h0;
    end else if (i_clk_en) begin
      if (i_double_fault) begin
        err_stat_ff[flash_seq_pkg::ERR_DF] <= 1'b1;
      end else if (i_reg.wr && (i_reg.addr == flash_seq_pkg::OFS_ERR_STATUS)
                   && i_reg.wdata[flash_seq_pkg::ERR_DF]) begin
        err_stat_ff[flash_seq_pkg::ERR_DF] <= 1'b0;
      end
      if (i_single_fault) begin
        err_stat_ff[flash_seq_pkg::ERR_SF] <= 1'b1;
      end else if (i_reg.wr && (i_reg.addr == flash_seq_pkg::OFS_ERR_STATUS)
                   && i_reg.wdata[flash_seq_pkg::ERR_SF]) begin
        err_stat_ff[flash_seq_pkg::ERR_SF] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rdata_ff <= 16'h0000;
    end else if (i_clk_en) begin
      rdata_ff <= 16'h0000;
      if (i_reg.rd) begin
        unique case (i_reg.addr)
          flash_seq_pkg::OFS_STATUS: rdata_ff <= {8'h00, status_word};
          flash_seq_pkg::OFS_CONFIG: rdata_ff <= {8'h00, config_ff};
          flash_seq_pkg::OFS_ERR_STATUS: rdata_ff <= {14'h0000, err_stat_ff};
          flash_seq_pkg::OFS_ERR_CONFIG: rdata_ff <= {14'h0000, err_cfg_ff};
          flash_seq_pkg::OFS_WORD_INDEX: rdata_ff <= {13'h0000, word_index_ff};
          flash_seq_pkg::OFS_PARAM: rdata_ff <= param_ff[word_index_ff];
          flash_seq_pkg::OFS_MODE: rdata_ff <= {14'h0000, mode_allow_ff};
          flash_seq_pkg::OFS_MARGIN: rdata_ff <= {12'h0000, field_margin_ff, user_margin_ff};
          default: rdata_ff <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_rdata = rdata_ff;
  assign o_ee_addr = ee_addr_ff;
  assign o_ee_rd = ee_rd_ff;
  assign o_user_margin = user_margin_ff;
  assign o_field_margin = field_margin_ff;
  // Levels, no clock: usable as a wake source while the processor waits
  assign o_cmd_irq = ccf_ff && config_ff[flash_seq_pkg::CFG_COMMAND_COMPLETE_IRQ_EN];
  assign o_err_irq = (err_stat_ff[flash_seq_pkg::ERR_DF] && err_cfg_ff[flash_seq_pkg::ERR_DF])
                     || (err_stat_ff[flash_seq_pkg::ERR_SF] && err_cfg_ff[flash_seq_pkg::ERR_SF]);
endmodule : flash_margin_verify_cmd_irq
`default_nettype wire

// file: src/flash_seq_pkg.sv
// Package for the flash margin/verify command sequencer
// Assumes a plain register port and an external EEPROM read port
package flash_seq_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CONFIG = 4'h1;
  localparam logic [3:0] OFS_ERR_STATUS = 4'h2;
  localparam logic [3:0] OFS_ERR_CONFIG = 4'h3;
  localparam logic [3:0] OFS_WORD_INDEX = 4'h4;
  localparam logic [3:0] OFS_PARAM = 4'h5;
  localparam logic [3:0] OFS_MODE = 4'h6;
  localparam logic [3:0] OFS_MARGIN = 4'h7;
  // ----------------------------------------
  // Field positions of the status, config and error registers
  // ----------------------------------------
  localparam int STAT_CCF = 7;
  localparam int STAT_ACC = 5;
  localparam int STAT_PROT = 4;
  localparam int STAT_VHI = 1;
  localparam int STAT_VLO = 0;
  localparam int CFG_COMMAND_COMPLETE_IRQ_EN = 7;
  localparam int ERR_DF = 1;
  localparam int ERR_SF = 0;
  // ----------------------------------------
  // Command codes and values
  // ----------------------------------------
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
  localparam logic [7:0] CMD_ERASE_VERIFY_EE = 8'h10;
  localparam logic [2:0] IDX_ONE = 3'h1;
  localparam logic [2:0] IDX_TWO = 3'h2;
  localparam logic [1:0] EE_BLOCK = 2'h0;
  localparam logic [1:0] PF_BLOCK = 2'h1;
  localparam logic [15:0] MARGIN_NORMAL = 16'h0000;
  localparam logic [15:0] MARGIN_ERASED = 16'h0001;
  localparam logic [15:0] MARGIN_PROGRAMMED = 16'h0002;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0] STATUS_RESET = 8'h80;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage : flash_seq_pkg
